// ### include/dcf_pkg.sv
/*
 * Package for the nine-bit FIFO with sampled write and read clocks:
 * sizes, register offsets, reset values, timing counts and shared types.
 * Assumes a single 50 MHz core clock that samples every pin.
 */
`default_nettype none
package dcf_pkg;
  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int unsigned DCF_WIDTH  = 9;      // Data word width
  localparam int unsigned DCF_AW     = 16;     // Pointer width, 64K variant
  localparam int unsigned DCF_CW     = 17;     // Word count width
  localparam logic [16:0] DCF_DEPTH  = 17'h10000; // Words held
  localparam int unsigned DCF_PIN_W  = 15;     // Sampled pin count
  localparam int unsigned DCF_EVT_W  = 6;      // Interrupt event count
  // ***********************************************************
  // Register map, byte offsets
  // ***********************************************************
  localparam logic [7:0] DCF_OFS_STATUS = 8'h00; // Sticky events, write 1 clears
  localparam logic [7:0] DCF_OFS_MASK   = 8'h04; // Interrupt mask
  localparam logic [7:0] DCF_OFS_AE     = 8'h08; // Almost-empty offset
  localparam logic [7:0] DCF_OFS_AF     = 8'h0c; // Almost-full offset
  localparam logic [7:0] DCF_OFS_LEVEL  = 8'h10; // Flags and word count
  // ***********************************************************
  // Reset values and field positions
  // ***********************************************************
  localparam logic [16:0] DCF_OFFSET_RST = 17'h00007; // Both offsets
  localparam logic [5:0]  DCF_MASK_RST   = 6'h00;
  localparam int unsigned DCF_LVL_FLAG_POS = 20; // Flags above the count
  // Event bit positions
  localparam int unsigned DCF_EV_FULL  = 0;
  localparam int unsigned DCF_EV_EMPTY = 1;
  localparam int unsigned DCF_EV_AF    = 2;
  localparam int unsigned DCF_EV_AE    = 3;
  localparam int unsigned DCF_EV_OVF   = 4;
  localparam int unsigned DCF_EV_UNF   = 5;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int unsigned DCF_CLK_NS = 20;  // Core clock period
  localparam int unsigned DCF_RETRANSMIT_RECOVERY_NS = 90;
  localparam int unsigned DCF_RTR_CYC =
    (DCF_RETRANSMIT_RECOVERY_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;
  // ***********************************************************
  // Types
  // ***********************************************************
  typedef struct packed {
    logic                 wclk;
    logic                 rclk;
    logic                 wen_n;
    logic                 ren_n;
    logic                 oe_n;
    logic                 rt_n;
    logic [DCF_WIDTH-1:0] d;
  } dcf_pins_t;

  typedef enum logic [1:0] {
    DCF_RT_IDLE = 2'b00,
    DCF_RT_BUSY = 2'b01
  } dcf_rt_state_t;
endpackage
`default_nettype wire

// ### rtl/dcf_fifo.sv
/*
 * Nine-bit 64K-word FIFO whose write and read clocks arrive as pins and
 * are sampled by the core clock, with boundary and threshold flags,
 * retransmit, an output-enabled data port and a small register port.
 * Assumes write and read clock pins run well below a quarter of the
 * core clock so every pin edge is seen after filtering.
 */
// Added by the designer: the placing of the registers and the plain strobed port.
// Summary of operation
// [RULE1] Full may clear one write edge late
// [RULE2] Empty may clear one read edge late
// [RULE3] Almost-empty updates on read edges only
// [RULE4] Almost-full updates on write edges only
// [RULE5] Clocks may run freely during reset
// [RULE6] After reset outputs low, three-state on OE
// [RULE7] First word readable cycle after empty clears
// [RULE8] Fall-through latency only at empty boundary
// [RULE9] Flags valid after retransmit recovery
// [RULE10] Threshold flags need one more edge
// [RULE11] Almost-full at depth minus full offset
// [RULE12] Both offsets reset to seven words
// [RULE13] Refuse writes when full, reads when empty
`default_nettype none
module dcf_fifo
  import dcf_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_wclk,
  input  wire logic                 i_rclk,
  input  wire logic                 i_wen_n,
  input  wire logic                 i_ren_n,
  input  wire logic [DCF_WIDTH-1:0] i_d,
  input  wire logic                 i_oe_n,
  input  wire logic                 i_rt_n,
  output logic      [DCF_WIDTH-1:0] o_q,
  output logic                      o_q_oe_n,
  output logic                      o_empty_flag_n,
  output logic                      o_full_flag_n,
  output logic                      o_almost_empty_flag_n,
  output logic                      o_almost_full_flag_n,
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  output logic                      o_irq
);
  // ***********************************************************
  // Pin sampling
  // ***********************************************************
  dcf_pins_t pins_raw;                    // Pins grouped
  logic [DCF_PIN_W-1:0] sync1;            // First stage, read only by sync2
  logic [DCF_PIN_W-1:0] sync2;            // Second stage
  logic [DCF_PIN_W-1:0] sync3;            // Third stage
  logic [DCF_PIN_W-1:0] filt;             // Accepted level
  dcf_pins_t pins;                        // Accepted levels as struct
  logic      wclk_d;                      // Previous accepted write clock
  logic      rclk_d;                      // Previous accepted read clock
  logic      rt_n_d;                      // Previous accepted retransmit

  assign pins_raw = '{wclk: i_wclk, rclk: i_rclk, wen_n: i_wen_n, ren_n: i_ren_n,
                      oe_n: i_oe_n, rt_n: i_rt_n, d: i_d};
  assign pins = dcf_pins_t'(filt);

  // Three stages per pin; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < DCF_PIN_W; gi++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi]  <= 1'b0;
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // Edge history; pin clocks keep toggling through reset harmlessly
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wclk_d <= 1'b0; // [RULE5]
      rclk_d <= 1'b0;
      rt_n_d <= 1'b1;
    end else begin
      wclk_d <= pins.wclk;
      rclk_d <= pins.rclk;
      rt_n_d <= pins.rt_n;
    end
  end

  // ***********************************************************
  // Events and acceptance
  // ***********************************************************
  logic              w_rise;              // Write clock rising edge seen
  logic              r_rise;              // Read clock rising edge seen
  logic              rt_start;            // Retransmit asserted
  logic              rt_busy;             // Recovery interval running
  logic              wr_req;              // Write asked for
  logic              rd_req;              // Read asked for
  logic              wr_acc;              // Write taken
  logic              rd_acc;              // Read taken
  logic [DCF_CW-1:0] count;               // Words stored
  logic [DCF_CW-1:0] next_count;          // Count after this cycle

  assign w_rise   = pins.wclk & ~wclk_d;
  assign r_rise   = pins.rclk & ~rclk_d;
  assign rt_start = ~pins.rt_n & rt_n_d;
  assign wr_req   = w_rise & ~pins.wen_n;
  assign rd_req   = r_rise & ~pins.ren_n;
  // Flags gate requests so pointers never overrun
  assign wr_acc   = wr_req & o_full_flag_n & ~rt_busy;  // [RULE13]
  assign rd_acc   = rd_req & o_empty_flag_n & ~rt_busy; // [RULE13]
  assign next_count = count + DCF_CW'(wr_acc) - DCF_CW'(rd_acc);

  // ***********************************************************
  // Storage and pointers
  // ***********************************************************
  logic [DCF_WIDTH-1:0] mem [0:DCF_DEPTH-1]; // Word store, no reset
  logic [DCF_AW-1:0]    wr_ptr;              // Next write slot
  logic [DCF_AW-1:0]    rd_ptr;              // Next read slot

  // Memory write, no reset so it maps onto block RAM
  always_ff @(posedge i_core_clk) begin
    if (wr_acc) begin
      mem[wr_ptr] <= pins.d;
    end
  end

  // Pointers and count; retransmit rewinds reads to slot zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (rt_start) begin
      // Limitation: replay is exact only while writes have not wrapped
      rd_ptr <= '0;                                  // [RULE9]
      count  <= {1'b0, wr_ptr};
    end else begin
      if (wr_acc) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_acc) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end

  // Output word; read register holds zero until the first read
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= '0;                                     // [RULE6]
    end else if (rd_acc) begin
      // Word lands one read edge after empty clears
      o_q <= mem[rd_ptr];                            // [RULE7] [RULE8]
    end
  end

  // Drive enable follows the filtered output-enable pin
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q_oe_n <= 1'b0;
    end else begin
      o_q_oe_n <= pins.oe_n;                         // [RULE6]
    end
  end

  // ***********************************************************
  // Retransmit recovery
  // ***********************************************************
  dcf_rt_state_t rt_state;                // Recovery state
  logic [2:0]    rt_cnt;                  // Recovery cycles left
  assign rt_busy = (rt_state == DCF_RT_BUSY);

  // Requests are refused until the recovery interval ends
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rt_state <= DCF_RT_IDLE;
      rt_cnt   <= '0;
    end else begin
      case (rt_state)
        DCF_RT_IDLE: begin
          if (rt_start) begin
            rt_state <= DCF_RT_BUSY;                 // [RULE9]
            rt_cnt   <= 3'(DCF_RTR_CYC - 1);
          end
        end
        DCF_RT_BUSY: begin
          if (rt_cnt == 3'h0) begin
            rt_state <= DCF_RT_IDLE;
          end else begin
            rt_cnt <= rt_cnt - 3'h1;
          end
        end
        default: begin
          rt_state <= DCF_RT_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************
  // Flags
  // ***********************************************************
  logic [DCF_CW-1:0] ae_off;              // Almost-empty offset
  logic [DCF_CW-1:0] af_off;              // Almost-full offset

  // Write-side flags change only on a seen write clock edge; a read just
  // after it shows up at the next write edge, the same slip the part allows
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_full_flag_n        <= 1'b1;
      o_almost_full_flag_n <= 1'b1;
    end else if (w_rise) begin
      o_full_flag_n        <= (next_count != DCF_DEPTH);        // [RULE1]
      // Low once count reaches depth minus offset
      o_almost_full_flag_n <= (next_count < DCF_DEPTH - af_off); // [RULE4] [RULE11] [RULE10]
    end
  end

  // Read-side flags change only on a seen read clock edge
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_empty_flag_n        <= 1'b0;
      o_almost_empty_flag_n <= 1'b0;
    end else if (r_rise) begin
      o_empty_flag_n        <= (next_count != '0);    // [RULE2]
      o_almost_empty_flag_n <= (next_count > ae_off); // [RULE3] [RULE10]
    end
  end

  // ***********************************************************
  // Register port
  // ***********************************************************
  logic [DCF_EVT_W-1:0] status;           // Sticky events
  logic [DCF_EVT_W-1:0] mask;             // Interrupt enables
  logic [DCF_EVT_W-1:0] events;           // This cycle's events
  logic                 full_n_d;         // Flag history for edges
  logic                 empty_n_d;
  logic                 af_n_d;
  logic                 ae_n_d;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      full_n_d  <= 1'b1;
      empty_n_d <= 1'b0;
      af_n_d    <= 1'b1;
      ae_n_d    <= 1'b0;
    end else begin
      full_n_d  <= o_full_flag_n;
      empty_n_d <= o_empty_flag_n;
      af_n_d    <= o_almost_full_flag_n;
      ae_n_d    <= o_almost_empty_flag_n;
    end
  end

  // Flag assertions and refused requests
  always_comb begin
    events = '0;
    events[DCF_EV_FULL]  = full_n_d & ~o_full_flag_n;
    events[DCF_EV_EMPTY] = empty_n_d & ~o_empty_flag_n;
    events[DCF_EV_AF]    = af_n_d & ~o_almost_full_flag_n;
    events[DCF_EV_AE]    = ae_n_d & ~o_almost_empty_flag_n;
    events[DCF_EV_OVF]   = wr_req & ~wr_acc;
    events[DCF_EV_UNF]   = rd_req & ~rd_acc;
  end

  // Status: set wins over a write-one clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status <= '0;
    end else if (i_wr && i_addr == DCF_OFS_STATUS) begin
      status <= (status & ~i_wdata[DCF_EVT_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  // Mask and offsets
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask   <= DCF_MASK_RST;
      ae_off <= DCF_OFFSET_RST;                      // [RULE12]
      af_off <= DCF_OFFSET_RST;                      // [RULE12]
    end else if (i_wr) begin
      if (i_addr == DCF_OFS_MASK) begin
        mask <= i_wdata[DCF_EVT_W-1:0];
      end else if (i_addr == DCF_OFS_AE) begin
        ae_off <= i_wdata[DCF_CW-1:0];
      end else if (i_addr == DCF_OFS_AF) begin
        af_off <= i_wdata[DCF_CW-1:0];
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == DCF_OFS_STATUS) begin
      o_rdata <= 32'(status);
    end else if (i_addr == DCF_OFS_MASK) begin
      o_rdata <= 32'(mask);
    end else if (i_addr == DCF_OFS_AE) begin
      o_rdata <= 32'(ae_off);
    end else if (i_addr == DCF_OFS_AF) begin
      o_rdata <= 32'(af_off);
    end else if (i_addr == DCF_OFS_LEVEL) begin
      o_rdata <= 32'(count) | (32'({o_almost_full_flag_n, o_almost_empty_flag_n,
                                    o_full_flag_n, o_empty_flag_n}) << DCF_LVL_FLAG_POS);
    end else begin
      o_rdata <= '0;
    end
  end

  // Level interrupt
  assign o_irq = |(status & mask);

  // ***********************************************************
  // Assertions
  // ***********************************************************
  logic read_seen;                        // Any read taken since reset
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      read_seen <= 1'b0;
    end else if (rd_acc) begin
      read_seen <= 1'b1;
    end
  end

  sequence s_rt_hold;
    rt_busy [*5];
  endsequence
  sequence s_rt_release;
    !rt_busy;
  endsequence

  AST_NO_WRITE_WHEN_FULL: assert property ( // [RULE13]
    @(posedge i_core_clk) disable iff (!i_resetn)
    wr_acc |-> o_full_flag_n && count != DCF_DEPTH)
    else $error("write taken while full");
  AST_NO_READ_WHEN_EMPTY: assert property ( // [RULE13]
    @(posedge i_core_clk) disable iff (!i_resetn)
    rd_acc |-> o_empty_flag_n && count != '0)
    else $error("read taken while empty");
  AST_FULL_ON_WRITE_EDGE: assert property ( // [RULE1]
    @(posedge i_core_clk) disable iff (!i_resetn)
    $changed(o_full_flag_n) |-> $past(w_rise))
    else $error("full flag moved off a write edge");
  AST_EMPTY_ON_READ_EDGE: assert property ( // [RULE2]
    @(posedge i_core_clk) disable iff (!i_resetn)
    $changed(o_empty_flag_n) |-> $past(r_rise))
    else $error("empty flag moved off a read edge");
  AST_AE_ON_READ_EDGE: assert property ( // [RULE3]
    @(posedge i_core_clk) disable iff (!i_resetn)
    r_rise |=> o_almost_empty_flag_n == (count > ae_off) || $past(rt_start))
    else $error("almost-empty flag wrong after read edge");
  AST_AF_THRESHOLD: assert property ( // [RULE4]
    @(posedge i_core_clk) disable iff (!i_resetn)
    w_rise && !rt_start |=> o_almost_full_flag_n == (count < DCF_DEPTH - af_off))
    else $error("almost-full flag wrong after write edge");
  AST_Q_ZERO_UNTIL_READ: assert property ( // [RULE6]
    @(posedge i_core_clk) disable iff (!i_resetn)
    !read_seen |-> o_q == '0)
    else $error("data output moved before any read");
  AST_FIRST_WORD_READ: assert property ( // [RULE7]
    @(posedge i_core_clk) disable iff (!i_resetn)
    rd_req && o_empty_flag_n && !rt_busy |=> $past(mem[rd_ptr]) == o_q)
    else $error("first word not delivered");
  AST_RT_RECOVERY: assert property ( // [RULE9]
    @(posedge i_core_clk) disable iff (!i_resetn)
    rt_start && !rt_busy |=> s_rt_hold ##1 s_rt_release)
    else $error("retransmit recovery length wrong");
endmodule
`default_nettype wire

// ### testbench/dcf_pin_partner.sv
/*
 * Writer and reader on the FIFO's pin side: free-running write and read
 * clocks with push and pop tasks that the bench calls by hierarchy.
 * Assumes the core clock is the only time base; pins change on its rise.
 */
`default_nettype none
module dcf_pin_partner
  import dcf_pkg::*;
(
  input  wire logic                 i_core_clk,
  output logic                      o_wclk,
  output logic                      o_rclk,
  output logic                      o_wen_n,
  output logic                      o_ren_n,
  output logic      [DCF_WIDTH-1:0] o_d
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // Pin clocks
  // ***********************************************************
  int unsigned wcnt; // Write clock phase counter
  int unsigned rcnt; // Read clock phase counter

  initial begin
    o_wclk  = 1'b0;
    o_rclk  = 1'b0;
    o_wen_n = 1'b1;
    o_ren_n = 1'b1;
    o_d     = '0;
    wcnt    = 0;
    rcnt    = 0;
  end

  // Periods of 8 and 10 core cycles keep the two clocks drifting apart
  // Never stopped, so reset and retransmit always see further edges
  always @(posedge i_core_clk) begin
    wcnt <= (wcnt == 3) ? 0 : wcnt + 1;
    rcnt <= (rcnt == 4) ? 0 : rcnt + 1;
    if (wcnt == 3) begin
      o_wclk <= ~o_wclk;
    end
    if (rcnt == 4) begin
      o_rclk <= ~o_rclk;
    end
  end

  // ***********************************************************
  // Transfers
  // ***********************************************************
  // One word around one write clock rise; data scrambled once released
  task automatic push(input logic [DCF_WIDTH-1:0] v);
    @(negedge o_wclk);
    o_wen_n <= 1'b0;
    o_d     <= v;
    @(posedge o_wclk);
    @(negedge o_wclk);
    o_wen_n <= 1'b1;
    o_d     <= ~v;
  endtask

  // One read enable held around one read clock rise
  task automatic pop();
    @(negedge o_rclk);
    o_ren_n <= 1'b0;
    @(posedge o_rclk);
    @(negedge o_rclk);
    o_ren_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench/dcf_fifo_bench.sv
/*
 * Self-checking bench for the nine-bit FIFO: reset state, refused reads,
 * first word, thresholds, retransmit and the register port.
 * Assumes the pin partner supplies the write and read side pins.
 */
`default_nettype none
module dcf_fifo_bench
  import dcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // Signals
  // ***********************************************************
  logic                 core_clk, resetn, oe_n, rt_n, wr, rd; // Bench driven
  logic [7:0]           addr;       // Register address
  logic [31:0]          wdata;      // Register write data
  logic [31:0]          rdata;      // Register read data
  logic [31:0]          d;          // Last register read
  logic [DCF_WIDTH-1:0] q, pd;      // Read data, pin write data
  logic                 q_oe_n, empty_n, full_n, ae_n, af_n, irq;
  logic                 wclk, rclk, wen_n, ren_n; // Partner pins
  int                   bad_count;   // Mismatches
  int                   checks_done; // Comparisons

  dcf_pin_partner partner (.i_core_clk(core_clk), .o_wclk(wclk), .o_rclk(rclk),
    .o_wen_n(wen_n), .o_ren_n(ren_n), .o_d(pd));

  dcf_fifo uut (.i_core_clk(core_clk), .i_resetn(resetn), .i_wclk(wclk),
    .i_rclk(rclk), .i_wen_n(wen_n), .i_ren_n(ren_n), .i_d(pd), .i_oe_n(oe_n),
    .i_rt_n(rt_n), .o_q(q), .o_q_oe_n(q_oe_n), .o_empty_flag_n(empty_n),
    .o_full_flag_n(full_n), .o_almost_empty_flag_n(ae_n),
    .o_almost_full_flag_n(af_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq));

  // ***********************************************************
  // Helpers
  // ***********************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ends just past an edge so later samples see settled values
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic flag(input int sel);
    case (sel)
      0:       return empty_n;
      1:       return ae_n;
      default: return af_n;
    endcase
  endfunction

  // Bounded wait for a flag; running out ends the run
  task automatic wait_flag(input int sel, input logic want, input int lim, input string nm);
    int i;
    i = 0;
    while (i < lim && flag(sel) !== want) begin
      cycles(1);
      i++;
    end
    chk(nm, 32'(want), 32'(flag(sel)));
    if (flag(sel) !== want) begin
      test_done();
    end
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_reset();
    chk("q", 32'h0, 32'(q));
    chk("q_oe_n", 32'h0, 32'(q_oe_n));
    // Empty and almost-empty low, full and almost-full high
    chk("flags", 32'h5, {28'h0, empty_n, full_n, ae_n, af_n});
    reg_rd(DCF_OFS_AE);
    chk("ae_offset", 32'h7, d);
    reg_rd(DCF_OFS_AF);
    chk("af_offset", 32'h7, d);
    oe_n <= 1'b1;
    cycles(6);
    chk("q_oe_n", 32'h1, 32'(q_oe_n));
    oe_n <= 1'b0;
    cycles(6);
    $display("test reset done");
  endtask

  task automatic t_refuse();
    reg_wr(DCF_OFS_MASK, 32'h20);
    partner.pop();
    cycles(3);
    chk("q_kept", 32'h0, 32'(q));
    reg_rd(DCF_OFS_STATUS);
    chk("read_refused", 32'h20, d & 32'h20);
    chk("irq", 32'h1, 32'(irq));
    reg_wr(DCF_OFS_STATUS, 32'h20);
    cycles(1);
    chk("irq", 32'h0, 32'(irq));
    reg_rd(8'h20);
    chk("unmapped", 32'h0, d);
    reg_wr(DCF_OFS_MASK, 32'h0);
    $display("test refuse done");
  endtask

  task automatic t_first();
    partner.push(9'h1a5);
    wait_flag(0, 1'b1, 30, "empty_n");
    partner.pop();
    cycles(2);
    chk("first_word", 32'h1a5, 32'(q));
    wait_flag(0, 1'b0, 30, "empty_n");
    $display("test first word done");
  endtask

  task automatic t_almost_empty();
    for (int i = 0; i < 7; i++) begin
      partner.push(9'h100 + 9'(i));
    end
    cycles(30);
    chk("ae_n", 32'h0, 32'(ae_n));
    partner.push(9'h107);
    wait_flag(1, 1'b1, 30, "ae_n");
    reg_rd(DCF_OFS_LEVEL);
    chk("count", 32'h8, d & 32'h1ffff);
    partner.pop();
    cycles(2);
    chk("fifo_order", 32'h100, 32'(q));
    wait_flag(1, 1'b0, 30, "ae_n");
    $display("test almost empty done");
  endtask

  // Offset of depth minus ten moves the threshold within reach
  task automatic t_almost_full();
    reg_wr(DCF_OFS_AF, {15'h0, DCF_DEPTH - 17'h0000a});
    partner.push(9'h0a1);
    partner.push(9'h0a2);
    cycles(30);
    chk("af_n", 32'h1, 32'(af_n));
    partner.push(9'h0a3);
    wait_flag(2, 1'b0, 30, "af_n");
    partner.pop();
    wait_flag(2, 1'b1, 30, "af_n");
    $display("test almost full done");
  endtask

  // Reset in mid-run with clocks running, then rewind after two reads
  task automatic t_retransmit();
    resetn <= 1'b0;
    cycles(2);
    resetn <= 1'b1;
    cycles(6);
    partner.push(9'h0c1);
    partner.push(9'h0c2);
    partner.push(9'h0c3);
    partner.pop();
    partner.pop();
    cycles(2);
    chk("second_word", 32'h0c2, 32'(q));
    rt_n <= 1'b0;
    cycles(4);
    rt_n <= 1'b1;
    cycles(DCF_RTR_CYC + 25);
    reg_rd(DCF_OFS_LEVEL);
    chk("count", 32'h3, d & 32'h1ffff);
    chk("flags", 32'h6, {29'h0, empty_n, full_n, ae_n});
    partner.pop();
    cycles(2);
    chk("rewound_word", 32'h0c1, 32'(q));
    $display("test retransmit done");
  endtask

  // ***********************************************************
  // Main sequence and watchdog
  // ***********************************************************
  initial begin
    resetn = 1'b0;
    oe_n = 1'b0;
    rt_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    cycles(6);
    t_reset();
    t_refuse();
    t_first();
    t_almost_empty();
    t_almost_full();
    t_retransmit();
    test_done();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
